// ===== rtl/mcs_pkg.sv
// types for the multichip clock-state sync block
// assumes mcs_regs.svh is included ahead of this package
`include "mcs_regs.svh"

package mcs_pkg;

  // operating mode of the surrounding synthesizer
  typedef enum logic [1:0] {
    mcs_mode_single_tone,
    mcs_mode_mod_parallel,
    mcs_mode_mod_serial,
    mcs_mode_interp_dac
  } mcs_mode_e;

  // static configuration bits, driven by the serial port shadow
  typedef struct packed {
    logic                    gen_enable;     // sync generator on
    logic                    rcv_enable;     // sync receiver on
    logic                    sync_polarity;  // 1: align to falling edge
    logic                    valid_disable;  // holds error latch reset
    mcs_mode_e               mode;           // operating mode
    logic [`MCS_R_W-1:0]     interp_factor;  // interpolation factor R
    logic [`MCS_R_W-1:0]     preset;         // sync state preset word
    logic [`MCS_DLY_W-1:0]   gen_delay;      // output delay word
    logic [`MCS_DLY_W-1:0]   rcv_delay;      // input delay word
  } mcs_cfg_s;

  // clock-tree state seen by the datapath
  typedef struct packed {
    logic sync_clk;     // common tree, system clock / 16
    logic half_clk;     // common tree, system clock / 2
    logic r_tick;       // R-divider terminal count strobe
    logic par_strobe;   // parallel-port tree strobe
    logic ser_strobe;   // serial-data tree strobe
  } mcs_clk_s;

endpackage

// ===== rtl/mcs_regs.svh
// constants for the multichip clock-state sync block
// assumes one system clock; sub-cycle delays live in pad delay cells
//
// Notes on behaviour
// - separate generator and receiver, both on system clock
// - generator drives 50% square clock when enabled
// - single tone or factor one: divide by 16
// - factor above one: divide by 16 times R
// - polarity bit picks rising or falling alignment
// - 5-bit generator delay word, about 75 ps/step
// - receiver needs enable; clock generator always runs
// - single pulse or periodic input; realign next edge
// - 5-bit receiver delay word, about 75 ps/step
// - one-cycle internal pulse per input period
// - rising edge sampled on system clock rising edge
// - pulse loads R-divider with 6-bit preset
// - preset lasts one cycle, then free counting
// - pulse also presets other dividers consistently
// - preset clamped to range 2 to R
// - three clock trees: common, parallel, serial
// - receiver disabled holds error latch in reset
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

// field widths
`define MCS_DLY_W      5
`define MCS_R_W        6
`define MCS_HALF_W     9

// common tree: sixteen system clocks per tick
`define MCS_CNT16_LAST 4'hF
`define MCS_CNT16_ZERO 4'h0
`define MCS_CNT16_ONE  4'h1

// divider and clamp figures
`define MCS_PRESET_MIN 6'h02
`define MCS_R_ONE      6'h01
`define MCS_R_ZERO     6'h00

// generator half period: eight clocks per unit of R
`define MCS_HALF_BASE  9'h008
`define MCS_HALF_SHIFT 3
`define MCS_HALF_ONE   9'h001
`define MCS_HALF_ZERO  9'h000

// reset values
`define MCS_DLY_RST    5'h00

`endif

// ===== rtl/mcs_sync.sv
// multichip clock-state sync: generator, receiver, clock generator
// assumes sync_in is already retimed to ref_clk by the pad delay cell;
// analog delay taps and validation latches live outside this module
`timescale 1ns/10ps
`include "mcs_regs.svh"

module mcs_sync (
  input  wire logic                    ref_clk,            // system clock, 20 MHz
  input  wire logic                    srst,               // sync reset, high
  input  wire mcs_pkg::mcs_cfg_s       cfg,                // configuration bits
  input  wire logic                    sync_in,            // delayed sync input
  input  wire logic                    setup_latch,        // setup validation latch
  input  wire logic                    hold_latch,         // hold validation latch
  output logic                         sync_out,           // generator clock out
  output logic                         sync_out_fall,      // pad retimes on falling edge
  output logic [`MCS_DLY_W-1:0]        out_delay_tap,      // output delay cell select
  output logic [`MCS_DLY_W-1:0]        in_delay_tap,       // input delay cell select
  output logic                         sync_pulse,         // one-cycle internal pulse
  output logic                         sample_error_output,// setup/hold error latch
  output logic [`MCS_R_W-1:0]          r_state,            // R-divider state
  output mcs_pkg::mcs_clk_s            clk_state           // clock-tree state
);

  // ----------------------------------------------------------------
  // derived factors
  // ----------------------------------------------------------------
  logic [`MCS_R_W-1:0]    r_eff;        // factor, zero read as one
  logic                   r_bypass;     // filter bypassed or single tone
  logic [`MCS_R_W-1:0]    preset_eff;   // clamped preset
  logic [`MCS_HALF_W-1:0] gen_half;     // generator half period

  // clamp and divide selection
  always_comb begin
    r_eff = (cfg.interp_factor == `MCS_R_ZERO) ? `MCS_R_ONE : cfg.interp_factor;
    r_bypass = (cfg.mode == mcs_pkg::mcs_mode_single_tone) || (r_eff == `MCS_R_ONE);
    // low values lifted first, then capped by R
    preset_eff = (cfg.preset < `MCS_PRESET_MIN) ? `MCS_PRESET_MIN : cfg.preset;
    if (preset_eff > r_eff) begin
      preset_eff = r_eff;
    end
    // half of 16 or of 16 times R
    if (r_bypass) begin
      gen_half = `MCS_HALF_BASE;
    end else begin
      gen_half = {{(`MCS_HALF_W-`MCS_R_W){1'b0}}, r_eff} << `MCS_HALF_SHIFT;
    end
  end

  // ----------------------------------------------------------------
  // sync generator, independent of the receiver
  // ----------------------------------------------------------------
  logic [`MCS_HALF_W-1:0] gen_cnt;        // half-period down counter
  logic [`MCS_HALF_W-1:0] next_gen_cnt;
  logic                   next_sync_out;
  logic                   next_sync_out_fall;
  logic [`MCS_DLY_W-1:0]  next_out_delay_tap;

  // toggle every half period for an exact 50% duty cycle
  always_comb begin
    next_sync_out_fall = cfg.sync_polarity;
    next_out_delay_tap = cfg.gen_delay;
    if (!cfg.gen_enable) begin
      // parked low, counter armed for a full first half
      next_sync_out = 1'b0;
      next_gen_cnt  = gen_half - `MCS_HALF_ONE;
    end else if (gen_cnt == `MCS_HALF_ZERO) begin
      next_sync_out = !sync_out;
      next_gen_cnt  = gen_half - `MCS_HALF_ONE;
    end else begin
      next_sync_out = sync_out;
      next_gen_cnt  = gen_cnt - `MCS_HALF_ONE;
    end
  end

  // generator registers; output edges sit on system clock edges
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_out      <= 1'b0;
      sync_out_fall <= 1'b0;
      out_delay_tap <= `MCS_DLY_RST;
      gen_cnt       <= `MCS_HALF_BASE - `MCS_HALF_ONE;
    end else begin
      sync_out      <= next_sync_out;
      sync_out_fall <= next_sync_out_fall;
      out_delay_tap <= next_out_delay_tap;
      gen_cnt       <= next_gen_cnt;
    end
  end

  // ----------------------------------------------------------------
  // sync receiver: edge detector and strobe
  // ----------------------------------------------------------------
  logic                  sync_in_q;        // previous sample of sync_in
  logic                  next_sync_pulse;
  logic [`MCS_DLY_W-1:0] next_in_delay_tap;

  // rising edge seen on a rising system clock edge; every edge
  // realigns, so a periodic input repairs a lost alignment
  always_comb begin
    next_in_delay_tap = cfg.rcv_delay;
    next_sync_pulse   = cfg.rcv_enable && sync_in && !sync_in_q;
  end

  // receiver registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_in_q    <= 1'b0;
      sync_pulse   <= 1'b0;
      in_delay_tap <= `MCS_DLY_RST;
    end else begin
      sync_in_q    <= sync_in;
      sync_pulse   <= next_sync_pulse;
      in_delay_tap <= next_in_delay_tap;
    end
  end

  // ----------------------------------------------------------------
  // setup/hold validation result latch
  // ----------------------------------------------------------------
  logic next_err;

  // mismatch is sticky until the disable bit or the receiver resets it;
  // a single bad edge must stay visible to software
  always_comb begin
    if (!cfg.rcv_enable || cfg.valid_disable) begin
      next_err = 1'b0;
    end else if (sync_pulse && (setup_latch != hold_latch)) begin
      next_err = 1'b1;
    end else begin
      next_err = sample_error_output;
    end
  end

  // error latch register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sample_error_output <= 1'b0;
    end else begin
      sample_error_output <= next_err;
    end
  end

  // ----------------------------------------------------------------
  // clock generator: runs whatever the receiver does
  // ----------------------------------------------------------------
  logic [3:0]          cnt16;       // common tree counter
  logic [3:0]          next_cnt16;
  logic [`MCS_R_W-1:0] next_r_state;
  logic                ser_phase;   // serial tree halves the R rate
  logic                next_ser_phase;
  mcs_pkg::mcs_clk_s   next_clk_state;
  logic                tick;        // common tree terminal count
  logic                r_wrap;      // R-divider reload

  // free run, or preset all trees in one cycle
  always_comb begin
    tick   = (cnt16 == `MCS_CNT16_LAST);
    r_wrap = tick && (r_state <= `MCS_R_ONE);
    if (sync_pulse) begin
      next_cnt16     = `MCS_CNT16_ZERO;
      next_r_state   = preset_eff;
      next_ser_phase = 1'b0;
    end else begin
      next_cnt16     = cnt16 + `MCS_CNT16_ONE;
      next_ser_phase = r_wrap ? !ser_phase : ser_phase;
      if (r_wrap) begin
        next_r_state = r_eff;
      end else if (tick) begin
        next_r_state = r_state - `MCS_R_ONE;
      end else begin
        next_r_state = r_state;
      end
    end
    // three trees: common always, parallel and serial by mode
    next_clk_state.sync_clk   = next_cnt16[3];
    next_clk_state.half_clk   = next_cnt16[0];
    next_clk_state.r_tick     = r_wrap && !sync_pulse;
    next_clk_state.par_strobe = r_wrap && !sync_pulse &&
                                ((cfg.mode == mcs_pkg::mcs_mode_mod_parallel) ||
                                 (cfg.mode == mcs_pkg::mcs_mode_interp_dac));
    next_clk_state.ser_strobe = r_wrap && !sync_pulse && ser_phase &&
                                (cfg.mode == mcs_pkg::mcs_mode_mod_serial);
  end

  // clock generator registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt16     <= `MCS_CNT16_ZERO;
      r_state   <= `MCS_R_ONE;
      ser_phase <= 1'b0;
      clk_state <= '0;
    end else begin
      cnt16     <= next_cnt16;
      r_state   <= next_r_state;
      ser_phase <= next_ser_phase;
      clk_state <= next_clk_state;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // internal pulse never stretches
  property p_pulse_one;
    sync_pulse |=> !sync_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("sync pulse longer than one cycle");

  // with the receiver enabled, a sampled rising edge yields the pulse
  property p_pulse_edge;
    (cfg.rcv_enable && sync_in && !sync_in_q) |=> sync_pulse;
  endproperty
  a_pulse_edge: assert property (p_pulse_edge) else $error("rising edge missed");

  // disabled receiver gives no pulse
  property p_no_pulse;
    !cfg.rcv_enable |=> !sync_pulse;
  endproperty
  a_no_pulse: assert property (p_no_pulse) else $error("pulse while receiver off");

  // pulse loads the clamped preset
  property p_preset_load;
    sync_pulse |=> (r_state == $past(preset_eff)) && (cnt16 == `MCS_CNT16_ZERO);
  endproperty
  a_preset_load: assert property (p_preset_load) else $error("divider not preset");

  // preset applies once, then counting resumes
  property p_free_run;
    (sync_pulse ##1 !sync_pulse) |=> cnt16 == `MCS_CNT16_ONE;
  endproperty
  a_free_run: assert property (p_free_run) else $error("preset held too long");

  // clamp bounds
  property p_clamp;
    (preset_eff <= r_eff) && ((preset_eff >= `MCS_PRESET_MIN) || (r_eff < `MCS_PRESET_MIN));
  endproperty
  a_clamp: assert property (p_clamp) else $error("preset out of range");

  // error latch cleared while receiver off
  property p_err_off;
    !cfg.rcv_enable |=> !sample_error_output;
  endproperty
  a_err_off: assert property (p_err_off) else $error("error latch not reset");

  // common tree keeps counting with receiver off; a pulse still in
  // flight from just before the disable may preset it once more
  property p_gen_runs;
    (!cfg.rcv_enable && !sync_pulse) |=> cnt16 == $past(cnt16) + `MCS_CNT16_ONE;
  endproperty
  a_gen_runs: assert property (p_gen_runs) else $error("clock generator stalled");

  // generator toggles at the end of each half period
  property p_out_toggle;
    (cfg.gen_enable && $past(cfg.gen_enable) && gen_cnt == `MCS_HALF_ZERO) |=> sync_out != $past(sync_out);
  endproperty
  a_out_toggle: assert property (p_out_toggle) else $error("sync out missed toggle");

  // bypass rate: eight high cycles per half
  property p_div16;
    ($rose(sync_out) && r_bypass && cfg.gen_enable && $stable(cfg)) |->
      (sync_out && $stable(cfg)) [*8] ##1 !sync_out;
  endproperty
  a_div16: assert property (p_div16) else $error("sync out not divide by 16");

endmodule

// ===== sim/mcs_sync_src.sv
// far-side model: a sync source driving the receiver input
// assumes the bench calls send() and drives skew on clock edges
`timescale 1ns/10ps

module mcs_sync_src (
  input  wire logic ref_clk,     // system clock
  input  wire logic skew,        // 1: validation latches disagree
  output logic      sync_in,     // delayed sync input
  output logic      setup_latch, // setup latch state
  output logic      hold_latch   // hold latch state
);
  initial sync_in = 1'b0;        // idle low between frames

  // latches follow the input; skew models a marginal edge
  assign setup_latch = sync_in;
  assign hold_latch  = sync_in ^ skew;

  // n periods of per cycles, 50% duty
  // per must be a multiple of 4, 16(R+M) or 32(R+M) for the mode
  task automatic send(input int n, input int per);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk) sync_in <= 1'b1;
      repeat (per / 2) @(posedge ref_clk);
      sync_in <= 1'b0;            // low again well before the next edge
      repeat (per / 2 - 1) @(posedge ref_clk);
    end
  endtask
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the multichip clock-state sync block
// assumes mcs_pkg is compiled first; the source model sits on sync_in
`timescale 1ns/10ps

module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic              ref_clk = 1'b0;   // 20 MHz system clock
  logic              srst    = 1'b1;   // reset held at start
  logic              skew    = 1'b0;   // latch mismatch request
  mcs_pkg::mcs_cfg_s cfg     = '0;     // configuration bits
  logic              sync_in, setup_latch, hold_latch;
  logic              sync_out, sync_out_fall, sync_pulse, err;
  logic [4:0]        out_tap, in_tap;  // delay tap copies
  logic [5:0]        r_state;          // R-divider state
  mcs_pkg::mcs_clk_s clk_state;        // clock-tree state
  logic              h0;               // half clock snapshot
  int                errors = 0, tests_run = 0, n_pulse = 0, n;
  logic [5:0]        pre [5] = '{6'h00, 6'h01, 6'h03, 6'h09, 6'h3F};
  logic [5:0]        exq [5] = '{6'h02, 6'h02, 6'h03, 6'h05, 6'h05};

  always #25 ref_clk = ~ref_clk;       // 50 ns period
  // pulse counter, used to see one pulse per input period
  always @(posedge ref_clk) if (sync_pulse === 1'b1) n_pulse++;

  mcs_sync u_dut (.ref_clk(ref_clk), .srst(srst), .cfg(cfg), .sync_in(sync_in),
    .setup_latch(setup_latch), .hold_latch(hold_latch), .sync_out(sync_out),
    .sync_out_fall(sync_out_fall), .out_delay_tap(out_tap), .in_delay_tap(in_tap),
    .sync_pulse(sync_pulse), .sample_error_output(err), .r_state(r_state), .clk_state(clk_state));
  mcs_sync_src u_src (.ref_clk(ref_clk), .skew(skew), .sync_in(sync_in),
    .setup_latch(setup_latch), .hold_latch(hold_latch));

  // ----------------------------------------
  // helper tasks
  // ----------------------------------------
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // settle past the edge so sampled outputs are stable
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask

  task automatic test_done;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // bounded wait for the receiver's pulse
  task automatic wait_pulse;
    int k;
    k = 0;
    while (sync_pulse !== 1'b1 && k < 8) begin
      tick(1);
      k++;
    end
  endtask

  // one edge with a given preset; checks pulse, clamp and free run
  task automatic sync_once(input logic [5:0] p, input logic [5:0] e);
    @(posedge ref_clk) cfg.preset <= p;
    fork u_src.send(1, 16); join_none
    wait_pulse;
    chk(sync_pulse, 1'b1);
    tick(1);
    chk(sync_pulse, 1'b0);
    chk(r_state, e);
    chk({clk_state.sync_clk, clk_state.half_clk}, 2'h0);
    tick(16);
    chk(r_state, e - 6'h01);
  endtask

  // restart generator in a mode, measure both half periods
  task automatic gen_half(input mcs_pkg::mcs_mode_e m, input logic [5:0] r, input int hx);
    int k, h, l;
    k = 0;
    // let a running high half finish so the rate check sees a whole half
    while (sync_out === 1'b1 && k < 600) begin tick(1); k++; end
    @(posedge ref_clk) cfg.gen_enable <= 1'b0;
    tick(2);
    chk(sync_out, 1'b0);
    @(posedge ref_clk) begin
      cfg.mode <= m;
      cfg.interp_factor <= r;
      cfg.gen_enable <= 1'b1;
    end
    k = 0;
    h = 0;
    l = 0;
    while (sync_out !== 1'b1 && k < 600) begin tick(1); k++; end
    while (sync_out === 1'b1 && h < 600) begin tick(1); h++; end
    while (sync_out === 1'b0 && l < 600) begin tick(1); l++; end
    chk(9'(h), 9'(hx));
    chk(9'(l), 9'(hx));
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    tick(1);
    chk({sync_out, sync_pulse, err}, 3'h0);
    chk(r_state, 6'h01);
    // delay words and polarity reach the pad controls
    @(posedge ref_clk) begin
      cfg.gen_delay <= 5'h15;
      cfg.rcv_delay <= 5'h0A;
      cfg.sync_polarity <= 1'b1;
    end
    tick(2);
    chk(out_tap, 5'h15);
    chk(in_tap, 5'h0A);
    chk(sync_out_fall, 1'b1);
    @(posedge ref_clk) cfg.sync_polarity <= 1'b0;
    tick(2);
    chk(sync_out_fall, 1'b0);
    // generator rate in each mode
    gen_half(mcs_pkg::mcs_mode_single_tone, 6'h05, 8);
    gen_half(mcs_pkg::mcs_mode_interp_dac, 6'h01, 8);
    gen_half(mcs_pkg::mcs_mode_mod_parallel, 6'h04, 32);
    gen_half(mcs_pkg::mcs_mode_mod_serial, 6'h03, 24);
    // receiver: clamp table with R = 5
    @(posedge ref_clk) begin
      cfg.rcv_enable <= 1'b1;
      cfg.mode <= mcs_pkg::mcs_mode_mod_parallel;
      cfg.interp_factor <= 6'h05;
    end
    tick(1);
    for (int i = 0; i < 5; i++) sync_once(pre[i], exq[i]);
    // periodic input: one pulse per period, realigns each edge
    @(posedge ref_clk) cfg.interp_factor <= 6'h02;
    n = n_pulse;
    u_src.send(4, 32);
    tick(4);
    chk(9'(n_pulse - n), 9'h004);
    // validation latch: set by mismatch, cleared by disable bit
    @(posedge ref_clk) skew <= 1'b1;
    fork u_src.send(1, 32); join_none
    wait_pulse;
    tick(2);
    chk(err, 1'b1);
    @(posedge ref_clk) cfg.valid_disable <= 1'b1;
    tick(2);
    chk(err, 1'b0);
    @(posedge ref_clk) cfg.valid_disable <= 1'b0;
    tick(20);
    fork u_src.send(1, 32); join_none
    wait_pulse;
    tick(2);
    chk(err, 1'b1);
    // receiver off: latch reset, no pulses, clocks still run
    @(posedge ref_clk) cfg.rcv_enable <= 1'b0;
    tick(2);
    chk(err, 1'b0);
    n = n_pulse;
    u_src.send(2, 32);
    tick(4);
    chk(9'(n_pulse - n), 9'h000);
    chk(err, 1'b0);
    h0 = clk_state.half_clk;
    tick(1);
    chk(clk_state.half_clk ^ h0, 1'b1);
    // parallel tree strobes on each R reload while the receiver is off
    n = 0;
    while (clk_state.par_strobe !== 1'b1 && n < 64) begin tick(1); n++; end
    chk({clk_state.r_tick, clk_state.par_strobe, clk_state.ser_strobe}, 3'h6);
    chk(r_state, 6'h02);
    tick(1);
    chk({clk_state.r_tick, clk_state.par_strobe}, 2'h0);
    test_done;
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    test_done;
  end
endmodule
